// ---- rtl/hisl_pkg.sv ----
// constants for the host interface script loader
package hisl_pkg;
   localparam logic [7:0]  ADDR_SLOT_INDEX  = 8'h7d;
   localparam logic [7:0]  ADDR_SCRIPT_PORT = 8'h7e;
   localparam logic [7:0]  ADDR_BUS_ADDR    = 8'h80;
   localparam logic [7:0]  ADDR_REVISION    = 8'h81;
   localparam logic [6:0]  BUS_ADDR_RESET   = 7'h44;
   localparam logic [6:0]  SLOTS_PER_TIMER  = 7'h20;
   localparam logic [6:0]  SLOT_LIMIT       = 7'h60;
   localparam int          NUM_TIMERS       = 3;
   localparam int          NUM_SLOTS        = 96;
   localparam int          BUS_ADDR_LSB     = 1;
   localparam int          SOFT_RESET_CYC   = 4;
   localparam logic [2:0]  SOFT_RESET_LEN   = 3'h4;
endpackage

// ---- rtl/hisl_script_store.sv ----
// script slot storage, one flip-flop word per slot
`timescale 1ns/100ps
module hisl_script_store #(
   parameter int DEPTH = 96,
   parameter int AW    = 7
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic          clr,
   // write side
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_idx,
   input  wire logic [15:0]   wr_word,
   // read side
   input  wire logic [AW-1:0] rd_idx,
   output logic      [15:0]   rd_word
);
   typedef struct packed {
      logic [DEPTH-1:0][15:0] mem;
   } hisl_store_t;
   hisl_store_t st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (clr) begin
         st_nxt.mem = '0;
      end else if (wr_en && (32'(wr_idx) < DEPTH)) begin
         st_nxt.mem[wr_idx] = wr_word;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_word = (32'(rd_idx) < DEPTH) ? st_r.mem[rd_idx] : 16'h0000;
endmodule

// ---- rtl/hisl_regs.sv ----
// host register bank: slot index, script port, bus address and revision/soft reset
// Notes on behaviour
// - index 0-31 timer0, 32-63 timer1, 64-95 timer2, slot is index mod 32
// - each complete script word lands in the slot the index selects when the index is below 96; at 96-127 it is dropped
// - index advances by one after every complete two-byte word
// - register address does not advance while on the script port
// - word bits 15:8 are the command high byte, 7:0 the low byte
// - shared address: write sets bus address, read returns maker code
// - new bus address takes effect only after the next stop
// - bus address in bits 7:1, reset 0x44, bit 0 reserved
// - in 10-bit addressing the upper three address bits read as zero
// - maker identifier is a read-only 8-bit field
// - revision address always reads the fixed revision number
// - writing the inverted revision triggers a full software reset
// - any other value written to the revision address is ignored
`timescale 1ns/100ps
module hisl_regs #(
   parameter logic [7:0] MAKER_ID    = 8'h5a, // arbitrary value
   parameter logic [7:0] REVISION_ID = 8'h3c  // arbitrary value
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // byte stream from the slave front end
   input  wire logic        wr_addr_valid,
   input  wire logic [7:0]  wr_addr,
   input  wire logic        wr_data_valid,
   input  wire logic [7:0]  wr_data,
   input  wire logic        rd_req,
   output logic      [7:0]  rd_data,
   output logic      [7:0]  cur_addr,
   input  wire logic        bus_start,
   input  wire logic        bus_stop,
   input  wire logic        ten_bit_mode,
   // slave address in use
   output logic      [6:0]  target_address_field,
   // script readback for the pwm engine
   input  wire logic [6:0]  engine_idx,
   output logic      [15:0] engine_word,
   output logic      [1:0]  slot_timer,
   output logic      [4:0]  slot_number,
   output logic             slot_valid,
   // soft reset pulse to the rest of the device
   output logic             soft_reset_out
);
   typedef struct packed {
      logic [7:0] addr;
      logic [6:0] script_slot_index;
      logic [7:0] hi_byte;
      logic       hi_held;
      logic [6:0] pend_addr;
      logic       pend_valid;
      logic [6:0] active_addr;
      logic [2:0] rst_cnt;
      logic [7:0] rd_data;
   } hisl_regs_t;

   hisl_regs_t st_r, st_nxt;
   logic        word_wr;
   logic [15:0] word_val;

   always_comb begin
      st_nxt  = st_r;
      word_wr = 1'b0;
      word_val = {st_r.hi_byte, wr_data};
      if (st_r.rst_cnt != 3'h0) begin
         st_nxt.rst_cnt = st_r.rst_cnt - 3'h1;
      end
      if (bus_start) begin
         st_nxt.hi_held = 1'b0; // a half word does not survive a new transaction
      end
      if (wr_addr_valid) begin
         st_nxt.addr    = wr_addr;
         st_nxt.hi_held = 1'b0;
      end else if (wr_data_valid) begin
         st_nxt.addr = st_r.addr + 8'h01;
         case (st_r.addr)
            hisl_pkg::ADDR_SLOT_INDEX: begin
               st_nxt.script_slot_index = wr_data[6:0];
            end
            hisl_pkg::ADDR_SCRIPT_PORT: begin
               st_nxt.addr = st_r.addr;
               if (!st_r.hi_held) begin
                  st_nxt.hi_byte = wr_data;
                  st_nxt.hi_held = 1'b1;
               end else begin
                  st_nxt.hi_held = 1'b0;
                  word_wr = (st_r.script_slot_index < hisl_pkg::SLOT_LIMIT);
                  st_nxt.script_slot_index = st_r.script_slot_index + 7'h01;
               end
            end
            hisl_pkg::ADDR_BUS_ADDR: begin
               st_nxt.pend_addr  = wr_data[7:hisl_pkg::BUS_ADDR_LSB];
               st_nxt.pend_valid = 1'b1;
            end
            hisl_pkg::ADDR_REVISION: begin
               if (wr_data == ~REVISION_ID) begin
                  st_nxt.rst_cnt = hisl_pkg::SOFT_RESET_LEN;
               end
               // other values fall through untouched
            end
            default: begin
            end
         endcase
      end
      if (rd_req) begin
         case (st_r.addr)
            hisl_pkg::ADDR_SLOT_INDEX:  st_nxt.rd_data = {1'b0, st_r.script_slot_index};
            hisl_pkg::ADDR_BUS_ADDR:    st_nxt.rd_data = MAKER_ID;
            hisl_pkg::ADDR_REVISION:    st_nxt.rd_data = REVISION_ID;
            default:                    st_nxt.rd_data = 8'h00;
         endcase
         if (st_r.addr != hisl_pkg::ADDR_SCRIPT_PORT) begin
            st_nxt.addr = st_r.addr + 8'h01;
         end
      end
      if (bus_stop && st_r.pend_valid) begin
         st_nxt.active_addr = st_r.pend_addr;
         st_nxt.pend_valid  = 1'b0;
      end
      if (st_r.rst_cnt == 3'h1) begin
         // soft reset returns the bank to its power-on contents
         st_nxt = '0;
         st_nxt.active_addr = hisl_pkg::BUS_ADDR_RESET;
         st_nxt.pend_addr   = hisl_pkg::BUS_ADDR_RESET;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r             <= '0;
         st_r.active_addr <= hisl_pkg::BUS_ADDR_RESET;
         st_r.pend_addr   <= hisl_pkg::BUS_ADDR_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   hisl_script_store #(
      .DEPTH (hisl_pkg::NUM_SLOTS),
      .AW    (7)
   ) u_store (
      .clk     (clk),
      .resetn  (resetn),
      .clr     (st_r.rst_cnt == 3'h1),
      .wr_en   (word_wr),
      .wr_idx  (st_r.script_slot_index),
      .wr_word (word_val),
      .rd_idx  (engine_idx),
      .rd_word (engine_word)
   );

   assign rd_data  = st_r.rd_data;
   assign cur_addr = st_r.addr;
   assign target_address_field = ten_bit_mode ? {3'b000, st_r.active_addr[3:0]}
                                              : st_r.active_addr;
   assign slot_timer  = st_r.script_slot_index[6:5];
   assign slot_number = st_r.script_slot_index[4:0];
   assign slot_valid  = (st_r.script_slot_index < hisl_pkg::SLOT_LIMIT);
   assign soft_reset_out = (st_r.rst_cnt != 3'h0);
endmodule

// ---- test/hisl_regs_chk.sv ----
// port checker for the host register bank
`timescale 1ns/100ps
module hisl_regs_chk #(
   parameter logic [7:0] MAKER_ID    = 8'h5a,
   parameter logic [7:0] REVISION_ID = 8'h3c
) (
   input wire logic        clk, resetn, wr_addr_valid, wr_data_valid, rd_req, bus_stop,
   input wire logic        ten_bit_mode, soft_reset_out, slot_valid,
   input wire logic [7:0]  wr_data, rd_data, cur_addr,
   input wire logic [6:0]  target_address_field, engine_idx,
   input wire logic [15:0] engine_word,
   input wire logic [1:0]  slot_timer
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // address byte wins over a data byte in the same cycle
   wire dw = wr_data_valid && !wr_addr_valid;
   a_rev_read: assert property (rd_req && cur_addr == 8'h81 |=> rd_data == REVISION_ID)
      else $error("bad revision");
   a_maker_read: assert property (rd_req && cur_addr == 8'h80 |=> rd_data == MAKER_ID)
      else $error("bad maker");
   a_port_stays: assert property (dw && cur_addr == 8'h7e |=> cur_addr == 8'h7e)
      else $error("port moved");
   // the ten-bit view is combinational, so a mode change alone may move the field
   a_addr_waits: assert property (!bus_stop && !soft_reset_out ##1 $stable(ten_bit_mode)
      |-> $stable(target_address_field)) else $error("address changed early");
   a_soft_length: assert property ($rose(soft_reset_out) |-> soft_reset_out[*4] ##1 !soft_reset_out)
      else $error("reset length");
   a_key_fires: assert property (dw && cur_addr == 8'h81 && wr_data == ~REVISION_ID && !soft_reset_out
      |=> $rose(soft_reset_out)) else $error("no reset");
   a_bad_key: assert property (dw && cur_addr == 8'h81 && wr_data != ~REVISION_ID && !soft_reset_out
      |=> !soft_reset_out) else $error("spurious reset");
   a_ten_bit: assert property (ten_bit_mode |-> target_address_field[6:4] == 3'h0)
      else $error("ten bit");
   a_high_slot: assert property (engine_idx >= 7'h60 |-> engine_word == 16'h0000)
      else $error("slot 96");
   a_timer_map: assert property (slot_valid |-> slot_timer != 2'h3)
      else $error("timer map");
   cover property ($rose(soft_reset_out));
   cover property (bus_stop);
   cover property (dw && cur_addr == 8'h7e);
endmodule
bind hisl_regs hisl_regs_chk #(.MAKER_ID(MAKER_ID), .REVISION_ID(REVISION_ID)) chk_u (.clk, .resetn,
   .wr_addr_valid, .wr_data_valid, .rd_req, .bus_stop, .ten_bit_mode, .soft_reset_out, .slot_valid, .wr_data,
   .rd_data, .cur_addr, .target_address_field, .engine_idx, .engine_word, .slot_timer);

// ---- test/hisl_host.sv ----
// host model: bus master byte stream toward the register bank
`timescale 1ns/100ps
module hisl_host (
   input  wire logic clk,
   output logic      av, dv, rq, stp, sta,
   output logic [7:0] ad, dt
);
   initial {av, dv, rq, stp, sta, ad, dt} = '0;
   task automatic put(input logic is_addr, input logic [7:0] v);
      @(posedge clk);
      {av, dv, ad, dt} <= {is_addr, !is_addr, v, v};
      @(posedge clk);
      // released data line shows garbage, not the last byte
      {av, dv, dt} <= {2'b00, ~v};
   endtask
   task automatic word(input logic [15:0] w);
      put(1'b0, w[15:8]);
      put(1'b0, w[7:0]);
   endtask
   task automatic pulse(input logic [1:0] k);
      @(posedge clk);
      {rq, stp, sta} <= {k == 2'd0, k == 2'd1, k == 2'd2};
      @(posedge clk);
      {rq, stp, sta} <= 3'b000;
   endtask
endmodule

// ---- test/host_iface_script_loader_bench.sv ----
// testbench for the host register bank
`timescale 1ns/100ps
module host_iface_script_loader_bench;
   localparam logic [7:0] MK = 8'h5a; // arbitrary value
   localparam logic [7:0] RV = 8'h3c; // arbitrary value
   logic        clk = 1'b0, resetn = 1'b0, ten = 1'b0, av, dv, rq, stp, sta, sval, srst;
   logic [7:0]  ad, dt, rd_data, cur_addr;
   logic [6:0]  tgt, eidx = 7'h00;
   logic [15:0] eword;
   logic [1:0]  stim;
   logic [4:0]  snum;
   int          num_errors = 0, n_tests = 0;
   always #25 clk = ~clk;
   hisl_host host_u (.clk, .av, .dv, .rq, .stp, .sta, .ad, .dt);
   hisl_regs #(.MAKER_ID(MK), .REVISION_ID(RV)) dut_u (.clk, .resetn, .wr_addr_valid(av), .wr_addr(ad),
      .wr_data_valid(dv), .wr_data(dt), .rd_req(rq), .rd_data, .cur_addr, .bus_start(sta), .bus_stop(stp),
      .ten_bit_mode(ten), .target_address_field(tgt), .engine_idx(eidx), .engine_word(eword),
      .slot_timer(stim), .slot_number(snum), .slot_valid(sval), .soft_reset_out(srst));
   task automatic check(input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      host_u.put(1'b1, a);
      host_u.put(1'b0, d);
   endtask
   task automatic rd(input logic [7:0] a, exp);
      host_u.put(1'b1, a);
      host_u.pulse(2'd0);
      #1 check(rd_data, exp);
   endtask
   task automatic peek(input logic [6:0] i, input logic [15:0] exp);
      @(posedge clk) eidx <= i;
      #1 check(eword, exp);
   endtask
   task automatic results;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #100000 num_errors++;
      results;
   end
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      #1 check(tgt, 7'h44);
      wr(8'h7d, 8'h1f);
      host_u.word(16'hab_cd);
      host_u.word(16'hef_01);
      #1 check(cur_addr, 8'h7e);
      check({sval, stim, snum}, {1'b1, 2'h1, 5'h01});
      peek(7'h1f, 16'hab_cd);
      peek(7'h20, 16'hef_01);
      rd(8'h7d, 8'h21);
      // a lone byte must not pair across a new start; the address stays on the port
      host_u.put(1'b1, 8'h7e);
      host_u.put(1'b0, 8'h99);
      host_u.pulse(2'd2);
      host_u.word(16'h12_34);
      peek(7'h21, 16'h12_34);
      wr(8'h7d, 8'h5f);
      host_u.word(16'h55_55);
      host_u.word(16'h66_66);
      peek(7'h5f, 16'h55_55);
      peek(7'h60, 16'h00_00);
      peek(7'h00, 16'h00_00);
      check(sval, 1'b0);
      rd(8'h7d, 8'h61);
      wr(8'h80, 8'h2a);
      #1 check(tgt, 7'h44);
      host_u.pulse(2'd1);
      @(posedge clk) #1 check(tgt, 7'h15);
      rd(8'h80, MK);
      @(posedge clk) ten <= 1'b1;
      #1 check(tgt, 7'h05);
      @(posedge clk) ten <= 1'b0;
      rd(8'h81, RV);
      wr(8'h81, 8'h00);
      repeat (2) @(posedge clk);
      #1 check(srst, 1'b0);
      wr(8'h81, ~RV);
      repeat (2) @(posedge clk);
      #1 check(srst, 1'b1);
      repeat (4) @(posedge clk);
      #1 check({srst, tgt}, {1'b0, 7'h44});
      rd(8'h7d, 8'h00);
      results;
   end
endmodule
